//--- pwr_defs.svh
// Constants for the power mode sequencer
// ============================================================
`ifndef PWR_DEFS_SVH
`define PWR_DEFS_SVH

`define CLK_PERIOD_PS      10000
`define SLEEP_WAKE_PS      1800000
`define STOP_WAKE_PS       5400000
`define STBY_WAKE_PS       50000000
`define SLEEP_WAKE_CYC     (`SLEEP_WAKE_PS / `CLK_PERIOD_PS)
`define STOP_WAKE_CYC      (`STOP_WAKE_PS / `CLK_PERIOD_PS)
`define STBY_WAKE_CYC      (`STBY_WAKE_PS / `CLK_PERIOD_PS)

`define REG_CTRL           8'h00
`define REG_PERI_EN        8'h04
`define REG_WAKE_SEL       8'h08
`define REG_STATUS         8'h0C
`define REG_BACKUP0        8'h10
`define REG_BACKUP1        8'h14
`define REG_BACKUP2        8'h18
`define REG_BACKUP3        8'h1C

`define CTRL_MODE_LSB      0
`define CTRL_TRX_OFF_BIT   2
`define CTRL_GO_BIT        3
`define PERI_EN_RST        16'h0000
`define WAKE_SEL_RST       16'h0000
`define BACKUP_RST         32'h0000_0000
`define NUM_BACKUP         4

`endif

//--- pwr_pkg.sv
// Types for the power mode sequencer
package pwr_pkg;

  typedef enum logic [4:0] {
    ST_BOOT    = 5'b00001,
    ST_RUN     = 5'b00010,
    ST_SLEEP   = 5'b00100,
    ST_STOP    = 5'b01000,
    ST_STANDBY = 5'b10000
  } pwr_state_t;

  typedef enum logic [1:0] {
    REQ_SLEEP   = 2'h1,
    REQ_STOP    = 2'h2,
    REQ_STANDBY = 2'h3
  } pwr_req_t;

  typedef struct packed {
    logic        core_clk_en;
    logic [15:0] peri_clk_en;
    logic        trx_power;
    logic        peri_power;
    logic        ram_retain;
    logic        io_analog;
    logic        core_reset;
  } pwr_ctl_t;

  typedef struct packed {
    logic        any_irq;
    logic        rtc_irq;
    logic        ext_irq;
    logic        wake_pin;
  } wake_src_t;

endpackage

//--- wake_timer.sv
// Wakeup latency counter
`timescale 1ns/1ps
module wake_timer
  import pwr_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         start,
  input  wire logic [W-1:0] count,
  // Status
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= count;
        busy  <= 1'b1;
      end else if (busy) begin
        if (cnt_r <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - W'(1);
        end
      end
    end
  end

endmodule

//--- boot_latch.sv
// Boot source capture after reset release
`timescale 1ns/1ps
module boot_latch (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Strap
  input  wire logic boot_source_select,
  input  wire logic recapture,
  // Result
  output logic      boot_loader
);

  logic taken_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_r     <= 1'b0;
      boot_loader <= 1'b0;
    end else if (!taken_r || recapture) begin
      taken_r     <= 1'b1;
      boot_loader <= boot_source_select;
    end
  end

endmodule

//--- power_mode_sequencer.sv
// Power mode sequencer top level
`timescale 1ns/1ps
`include "pwr_defs.svh"
module power_mode_sequencer
  import pwr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Wake sources
  input  wire wake_src_t   wake,
  input  wire logic [15:0] peri_irq,
  input  wire logic        cpu_wfi,
  // Boot strap
  input  wire logic        boot_source_select,
  // Power controls
  output pwr_ctl_t         ctl,
  output logic             boot_loader,
  output logic             resume
);

  // ==========================================================
  // Registers
  pwr_state_t  state_r;
  pwr_state_t  state_nxt;
  logic [1:0]  req_mode_r;
  logic        go_r;
  logic        trx_off_r;
  logic [15:0] peri_en_r;
  logic [15:0] wake_sel_r;
  logic [31:0] backup_r [`NUM_BACKUP];
  logic        from_stby_r;
  logic        tmr_start;
  logic [15:0] tmr_count;
  logic        tmr_busy;
  logic        tmr_done;
  logic        wake_ev;
  logic [1:0]  bidx;
  logic        in_boot;
  logic        ctrl_wr;
  logic        peri_wr;
  logic        wsel_wr;
  logic        sleep_wake;
  logic        stop_wake;
  logic        stby_wake;

  // Wake latencies in core clock cycles
  localparam logic [15:0] SLP_CYC = 16'(`SLEEP_WAKE_CYC);
  localparam logic [15:0] STP_CYC = 16'(`STOP_WAKE_CYC);
  localparam logic [15:0] SBY_CYC = 16'(`STBY_WAKE_CYC);

  assign bidx = addr[3:2];

  // ==========================================================
  // Software writes
  // A reset restart clears trx_off_r, peri_en_r and wake_sel_r but keeps req_mode_r, and blocks writes other than to the backup registers
  assign in_boot = (state_r == ST_BOOT) || (state_nxt == ST_BOOT);
  assign ctrl_wr = wr && !in_boot && (addr == `REG_CTRL);
  assign peri_wr = wr && !in_boot && (addr == `REG_PERI_EN);
  assign wsel_wr = wr && !in_boot && (addr == `REG_WAKE_SEL);

  // Mode request; go lasts one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_mode_r <= 2'h0;
      go_r       <= 1'b0;
    end else begin
      go_r <= ctrl_wr && wdata[`CTRL_GO_BIT];
      if (ctrl_wr) begin
        req_mode_r <= wdata[`CTRL_MODE_LSB +: 2];
      end
    end
  end

  // Transceiver power-down request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trx_off_r <= 1'b0;
    end else if (in_boot) begin
      trx_off_r <= 1'b0;
    end else if (ctrl_wr) begin
      trx_off_r <= wdata[`CTRL_TRX_OFF_BIT];
    end
  end

  // Peripheral clock enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peri_en_r <= `PERI_EN_RST;
    end else if (in_boot) begin
      peri_en_r <= `PERI_EN_RST;
    end else if (peri_wr) begin
      peri_en_r <= wdata[15:0];
    end
  end

  // Wake source selection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_sel_r <= `WAKE_SEL_RST;
    end else if (in_boot) begin
      wake_sel_r <= `WAKE_SEL_RST;
    end else if (wsel_wr) begin
      wake_sel_r <= wdata[15:0];
    end
  end

  // Backup registers are never cleared by mode changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `NUM_BACKUP; i++) begin
        backup_r[i] <= `BACKUP_RST;
      end
    end else if (wr && addr[7:4] == 4'h1) begin
      backup_r[bidx] <= wdata;
    end
  end

  // ==========================================================
  // Wake qualification
  assign sleep_wake = wake.any_irq | (|(peri_irq & wake_sel_r));
  assign stop_wake  = wake.rtc_irq | wake.ext_irq;
  assign stby_wake  = wake.rtc_irq | wake.wake_pin;

  always_comb begin
    wake_ev = 1'b0;
    unique case (state_r)
      ST_SLEEP:   wake_ev = sleep_wake;
      ST_STOP:    wake_ev = stop_wake;
      ST_STANDBY: wake_ev = stby_wake;
      default:    wake_ev = 1'b0;
    endcase
  end

  // ==========================================================
  // Mode sequencer
  // Wake latency of the mode being left
  always_comb begin
    unique case (state_r)
      ST_STOP:    tmr_count = STP_CYC;
      ST_STANDBY: tmr_count = SBY_CYC;
      default:    tmr_count = SLP_CYC;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    unique case (state_r)
      ST_BOOT: state_nxt = ST_RUN;
      ST_RUN: begin
        if (go_r && cpu_wfi) begin
          unique case (req_mode_r)
            2'h1:    state_nxt = ST_SLEEP;
            2'h2:    state_nxt = ST_STOP;
            2'h3:    state_nxt = ST_STANDBY;
            default: state_nxt = ST_RUN;
          endcase
        end
      end
      ST_SLEEP, ST_STOP, ST_STANDBY: begin
        // A finishing count must not restart on a still-high wake
        if (wake_ev && !tmr_busy && !tmr_done) begin
          tmr_start = 1'b1;
        end
        if (tmr_done) begin
          state_nxt = (state_r == ST_STANDBY) ? ST_BOOT : ST_RUN;
        end
      end
      default: state_nxt = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Standby marker for the strap recapture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      from_stby_r <= 1'b0;
    end else if (state_r == ST_STANDBY) begin
      from_stby_r <= 1'b1;
    end else if (state_r == ST_RUN) begin
      from_stby_r <= 1'b0;
    end
  end

  // Resume at the stop point for sleep and stop only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resume <= 1'b0;
    end else begin
      resume <= tmr_done &&
                (state_r == ST_SLEEP || state_r == ST_STOP);
    end
  end

  wake_timer #(
    .W (16)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (tmr_start),
    .count (tmr_count),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  boot_latch u_boot (
    .clk                (clk),
    .rst_n              (rst_n),
    .boot_source_select (boot_source_select),
    .recapture          (state_r == ST_BOOT && from_stby_r),
    .boot_loader        (boot_loader)
  );

  // ==========================================================
  // Power and clock controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= '{core_clk_en: 1'b0, peri_clk_en: 16'h0000, trx_power: 1'b0,
               peri_power: 1'b1, ram_retain: 1'b1, io_analog: 1'b0,
               core_reset: 1'b1};
    end else begin
      unique case (state_nxt)
        ST_BOOT: begin
          ctl.core_clk_en <= 1'b0;
          ctl.peri_clk_en <= 16'h0000;
          ctl.trx_power   <= 1'b0;
          ctl.peri_power  <= 1'b1;
          ctl.ram_retain  <= 1'b0;
          ctl.io_analog   <= 1'b0;
          ctl.core_reset  <= 1'b1;
        end
        ST_RUN: begin
          ctl.core_clk_en <= 1'b1;
          ctl.peri_clk_en <= peri_en_r;
          ctl.trx_power   <= !trx_off_r;
          ctl.peri_power  <= 1'b1;
          ctl.ram_retain  <= 1'b1;
          ctl.io_analog   <= 1'b0;
          ctl.core_reset  <= 1'b0;
        end
        ST_SLEEP: begin
          ctl.core_clk_en <= 1'b0;
          ctl.peri_clk_en <= peri_en_r & wake_sel_r;
          ctl.trx_power   <= !trx_off_r && wake_sel_r[0];
          ctl.peri_power  <= 1'b1;
          ctl.ram_retain  <= 1'b1;
          ctl.io_analog   <= 1'b0;
          ctl.core_reset  <= 1'b0;
        end
        ST_STOP: begin
          ctl.core_clk_en <= 1'b0;
          ctl.peri_clk_en <= 16'h0000;
          ctl.trx_power   <= !trx_off_r && wake_sel_r[0];
          ctl.peri_power  <= 1'b1;
          ctl.ram_retain  <= 1'b1;
          ctl.io_analog   <= 1'b0;
          ctl.core_reset  <= 1'b0;
        end
        ST_STANDBY: begin
          ctl.core_clk_en <= 1'b0;
          ctl.peri_clk_en <= 16'h0000;
          ctl.trx_power   <= 1'b0;
          ctl.peri_power  <= 1'b0;
          ctl.ram_retain  <= 1'b0;
          ctl.io_analog   <= 1'b1;
          ctl.core_reset  <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= 32'h0000_0000;
      unique case (addr)
        `REG_CTRL:     rdata <= {28'h0, 1'b0, trx_off_r, req_mode_r};
        `REG_PERI_EN:  rdata <= {16'h0, peri_en_r};
        `REG_WAKE_SEL: rdata <= {16'h0, wake_sel_r};
        `REG_STATUS:   rdata <= {25'h0, boot_loader, tmr_busy, state_r};
        `REG_BACKUP0, `REG_BACKUP1, `REG_BACKUP2, `REG_BACKUP3:
          rdata <= backup_r[bidx];
        default:       rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

//--- pms_sva.sv
// Port assertions for the power mode sequencer
`timescale 1ns/1ps
module pms_sva
  import pwr_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched ports
  input wire wake_src_t   wake,
  input wire logic [15:0] peri_irq,
  input wire logic        cpu_wfi,
  input wire logic        boot_source_select,
  input wire pwr_ctl_t    ctl,
  input wire logic        boot_loader,
  input wire logic        resume
);
  // ============================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_released;
    $past(rst_n) == 1'b0;
  endsequence
  sequence s_no_wake;
    !(|wake) && !(|peri_irq);
  endsequence
  AST_RUN_AFTER_RESET: assert property (
    s_released |=> ctl.core_clk_en && !ctl.core_reset)
    else $error("run mode missing after reset");
  AST_BOOT_CAPTURE: assert property (
    s_released |=> boot_loader == $past(boot_source_select))
    else $error("strap not captured");
  AST_STANDBY_POWER: assert property (
    ctl.io_analog |-> !ctl.trx_power && !ctl.peri_power && !ctl.ram_retain)
    else $error("standby power wrong");
  AST_STANDBY_NO_RESUME: assert property (
    ctl.io_analog |-> !resume && !ctl.core_clk_en)
    else $error("standby resumed in place");
  AST_RESUME_PULSE: assert property (
    resume |=> !resume)
    else $error("resume longer than one cycle");
  AST_RESUME_CORE: assert property (
    resume |-> ##[0:1] ctl.core_clk_en)
    else $error("core clock off after resume");
  AST_ENTRY_WFI: assert property (
    $fell(ctl.core_clk_en) |-> $past(cpu_wfi))
    else $error("low power without wfi");
  AST_LOWPOWER_IO: assert property (
    !ctl.core_clk_en && ctl.peri_power |-> !ctl.io_analog)
    else $error("pins changed in sleep or stop");
  AST_RESUME_CAUSE: assert property (
    s_no_wake |=> !$rose(resume))
    else $error("resume without wake source");
endmodule
bind power_mode_sequencer pms_sva u_sva (.clk, .rst_n, .wake, .peri_irq,
  .cpu_wfi, .boot_source_select, .ctl, .boot_loader, .resume);

//--- wake_agent.sv
// Software, strap and wake source model at the far side
`timescale 1ns/1ps
module wake_agent
  import pwr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bench control
  input  wire wake_src_t   set,
  input  wire logic        clr,
  input  wire logic        wfi_ok,
  input  wire logic        want_loader,
  // Observed
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        resume,
  input  wire pwr_ctl_t    ctl,
  // Driven
  output wake_src_t        wake,
  output logic             cpu_wfi,
  output logic             boot_source_select
);
  // ============================================================
  // Strap held through reset when the loader is wanted
  assign boot_source_select = want_loader;
  // Core executes its sleep instruction right after a go write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cpu_wfi <= 1'b0;
    else if (wr && addr == 8'h00 && wdata[3] && wfi_ok)
      cpu_wfi <= 1'b1;
    else if (resume || ctl.core_reset)
      cpu_wfi <= 1'b0;
  end
  // Interrupt levels stay until serviced or cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      wake <= '0;
    else if (clr || resume)
      wake <= '0;
    else
      wake <= wake | set;
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the power mode sequencer
`timescale 1ns/1ps
module tb_top
  import pwr_pkg::*;
;
  logic        clk, rst_n, wr, rd, cpu_wfi, boot_source_select;
  logic        boot_loader, resume, clr, wfi_ok, want_loader, seen_rst;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [15:0] peri_irq;
  wake_src_t   wake, set;
  pwr_ctl_t    ctl;
  int          num_errors, checks_done, n, hits;
  logic [3:0]  go [5] = '{4'h9, 4'hA, 4'hA, 4'hB, 4'hB};
  logic [3:0]  bad [5] = '{4'h0, 4'h8, 4'h8, 4'h2, 4'h2};
  logic [3:0]  good [5] = '{4'h8, 4'h4, 4'h2, 4'h4, 4'h1};
  logic [4:0]  st [5] = '{5'h04, 5'h08, 5'h08, 5'h10, 5'h10};
  int          lat [5] = '{180, 540, 540, 5000, 5000};

  power_mode_sequencer dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .wake, .peri_irq, .cpu_wfi, .boot_source_select, .ctl, .boot_loader,
    .resume);
  wake_agent model (.clk, .rst_n, .set, .clr, .wfi_ok, .want_loader, .addr,
    .wdata, .wr, .resume, .ctl, .wake, .cpu_wfi, .boot_source_select);

  // ============================================================
  // Tasks
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ============================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
    peri_irq = '0; set = '0; clr = 1'b0; wfi_ok = 1'b1; want_loader = 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("boot_loader", boot_loader, 1'b1);
    chk("run_ctl", {ctl.core_clk_en, ctl.core_reset}, 2'b10);
    rd_reg(8'h0C, v);
    chk("status", v[6:0], 7'h42);
    wr_reg(8'h10, 32'hA5A5_0001);
    rd_reg(8'h24, v);
    chk("unmapped", v, 32'h0);
    wr_reg(8'h04, 32'h0000_00F3);
    wr_reg(8'h08, 32'h0000_0001);
    wr_reg(8'h00, 32'h0000_0004);
    @(posedge clk);
    #1 chk("peri_clk", ctl.peri_clk_en, 16'h00F3);
    chk("trx_off", ctl.trx_power, 1'b0);
    wr_reg(8'h00, 32'h0000_0000);
    wfi_ok <= 1'b0;
    wr_reg(8'h00, 32'h0000_0009);
    repeat (3) @(posedge clk);
    #1 chk("no_wfi", ctl.core_clk_en, 1'b1);
    wfi_ok <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h00, {28'h0, go[i]});
      repeat (3) @(posedge clk);
      #1 chk("core_off", ctl.core_clk_en, 1'b0);
      if (i < 3) begin
        chk("retain", {ctl.ram_retain, ctl.io_analog}, 2'b10);
        chk("wake_clk", ctl.peri_clk_en, i == 0 ? 16'h1 : 16'h0);
        wr_reg(8'h00, 32'h0000_0009);
        rd_reg(8'h0C, v);
        chk("lp_state", v[4:0], st[i]);
      end else
        chk("standby", {ctl.trx_power, ctl.peri_power,
          ctl.ram_retain, ctl.io_analog}, 4'b0001);
      @(posedge clk);
      peri_irq <= 16'h0002;
      set <= wake_src_t'(bad[i]);
      @(posedge clk);
      set <= '0;
      hits = 0;
      repeat (600) begin
        @(posedge clk);
        #1 hits += (resume || ctl.core_clk_en);
      end
      chk("bad_wake", hits, 0);
      @(posedge clk);
      clr <= 1'b1;
      peri_irq <= '0;
      @(posedge clk);
      clr <= 1'b0;
      set <= wake_src_t'(good[i]);
      @(posedge clk);
      set <= '0;
      seen_rst = 1'b0;
      for (n = 1; n < 6000; n++) begin
        @(posedge clk);
        #1 seen_rst |= ctl.core_reset;
        if (i < 3 ? resume : ctl.core_clk_en) break;
      end
      if (n >= 6000) begin
        num_errors++;
        give_verdict();
      end
      chk("latency", n >= lat[i] && n <= lat[i] + 8, 1'b1);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      rd_reg(8'h10, v);
      chk("backup", v, 32'hA5A5_0001);
      if (i >= 3) begin
        chk("reset_seq", seen_rst, 1'b1);
        rd_reg(8'h04, v);
        chk("peri_rst", v, 32'h0);
      end
    end
    give_verdict();
  end
endmodule
